// ---- design/pci_status_consts.vh ----
// constants for the configuration status register block
`ifndef PCI_STATUS_CONSTS_VH
`define PCI_STATUS_CONSTS_VH
// dword offsets in configuration space
`define CFG_OFF_CMD_STATUS 8'h04
`define CFG_OFF_CAP_PTR 8'h34
// status bit positions within the dword
`define ST_DET_PAR 31
`define ST_SIG_SERR 30
`define ST_RCV_MABORT 29
`define ST_RCV_TABORT 28
`define ST_SIG_TABORT 27
`define ST_DEVSEL_HI 26
`define ST_DEVSEL_LO 25
`define ST_MDATA_PAR 24
`define ST_FAST_B2B 23
`define ST_CAP_LIST 20
// command bit positions
`define CMD_PAR_RESP 6
`define CMD_SERR_EN 8
`define CMD_WIDTH 11
`define CMD_WRITE_MASK 11'h157
`define CMD_RESET 11'h000
// fixed field values
`define DEVSEL_MEDIUM 2'h1
`define CAP_PTR_DEFAULT 8'hdc
`define STICKY_RESET 1'h0
`endif

// ---- design/pci_config_status_register.v ----
// configuration command/status dword with sticky bus event flags
//
// Summary of operation
// - detected parity error flag sets on any parity error, regardless of parity response.
// - signalled system error flag sets whenever the device drives SERR.
// - received master abort flag sets when our master cycle master-aborts.
// - received target abort flag sets when our master cycle is target-aborted.
// - signalled target abort bit always reads zero.
// - devsel timing field always reads medium, 01.
// - master parity flag sets on PERR while mastering with parity response on.
// - fast back-to-back capable bit always reads one.
// - capabilities list bit mirrors the power management enable from EEPROM.
// - capabilities pointer holds offset of first capability item while power management is enabled, else reads zero.
// - reserved bits 19 to 16 read zero.
// - bits 21 and 22 read zero.
// - command parity response bit gates parity action, resets to zero.
// - command SERR enable gates the SERR driver, resets to zero.
`timescale 1ns/1ps
`include "pci_status_consts.vh"
module pci_config_status_register #(
    parameter [7:0] CAP_PTR = `CAP_PTR_DEFAULT
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_reset,
    // configuration access from the target logic
    input wire i_cfg_wr,
    input wire i_cfg_rd,
    input wire [7:0] i_cfg_addr,
    input wire [3:0] i_cfg_be,
    input wire [31:0] i_cfg_wdata,
    output reg [31:0] o_cfg_rdata,
    output reg o_cfg_ack,
    // event pulses from master and target logic
    input wire i_parity_err,
    input wire i_addr_parity_err,
    input wire i_perr_seen,
    input wire i_master_active,
    input wire i_master_abort,
    input wire i_target_abort,
    // eeprom strap, power management enable
    input wire i_pm_enable,
    // control out
    output reg o_serr_drive,
    output reg o_par_resp_en,
    output reg o_serr_en
);

// ----------------------------------------
// state
// ----------------------------------------
reg [`CMD_WIDTH-1:0] command;
reg det_par;
reg sig_serr;
reg rcv_mabort;
reg rcv_tabort;
reg mdata_par;
reg pm_enable;
wire hit_cs;
wire hit_cap;
wire wr_cs;
wire wr_hi;
wire serr_event;
wire set_det_par;
wire set_sig_serr;
wire set_rcv_mabort;
wire set_rcv_tabort;
wire set_mdata_par;
wire clr_det_par;
wire clr_sig_serr;
wire clr_rcv_mabort;
wire clr_rcv_tabort;
wire clr_mdata_par;
wire [15:0] status_word;
wire [`CMD_WIDTH-1:0] next_command;

// ----------------------------------------
// address decode
// ----------------------------------------
assign hit_cs = (i_cfg_addr == `CFG_OFF_CMD_STATUS);
assign hit_cap = (i_cfg_addr == `CFG_OFF_CAP_PTR);
assign wr_cs = i_cfg_wr & hit_cs;
// status write-one-clear needs the upper byte lane
assign wr_hi = wr_cs & i_cfg_be[3];

// ----------------------------------------
// event qualification
// ----------------------------------------
// serr only when enabled and parity response on
assign serr_event = i_addr_parity_err & command[`CMD_SERR_EN] & command[`CMD_PAR_RESP];
// detection is recorded even with parity response off
assign set_det_par = i_parity_err | i_addr_parity_err;
// the flag follows the pin request, so it lags the event by two clocks
assign set_sig_serr = o_serr_drive;
assign set_rcv_mabort = i_master_abort;
assign set_rcv_tabort = i_target_abort;
// all three together: perr, our own master cycle, response on
assign set_mdata_par = i_perr_seen & i_master_active & command[`CMD_PAR_RESP];

// ----------------------------------------
// write-one-clear strobes
// ----------------------------------------
// a zero data bit leaves its flag alone
assign clr_det_par = wr_hi & i_cfg_wdata[`ST_DET_PAR];
assign clr_sig_serr = wr_hi & i_cfg_wdata[`ST_SIG_SERR];
assign clr_rcv_mabort = wr_hi & i_cfg_wdata[`ST_RCV_MABORT];
assign clr_rcv_tabort = wr_hi & i_cfg_wdata[`ST_RCV_TABORT];
assign clr_mdata_par = wr_hi & i_cfg_wdata[`ST_MDATA_PAR];

// ----------------------------------------
// read image
// ----------------------------------------
// unlisted bits are constant zero, so writes never reach them
assign status_word = {det_par, sig_serr, rcv_mabort, rcv_tabort,
                      1'h0,
                      `DEVSEL_MEDIUM,
                      mdata_par,
                      1'h1,
                      2'h0,
                      pm_enable,
                      4'h0};

// only writable command bits take byte-lane data
assign next_command = (command & ~`CMD_WRITE_MASK) |
                      ({i_cfg_be[1] ? i_cfg_wdata[10:8] : command[10:8],
                        i_cfg_be[0] ? i_cfg_wdata[7:0] : command[7:0]} & `CMD_WRITE_MASK);

// ----------------------------------------
// command register
// ----------------------------------------
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        command <= `CMD_RESET;
    else if (i_cfg_wr && hit_cs)
        command <= next_command;
end

// ----------------------------------------
// sticky flags, a set beats a same-cycle clear
// ----------------------------------------
// detected parity error
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        det_par <= `STICKY_RESET;
    else
        det_par <= set_det_par | (det_par & ~clr_det_par);
end

// signalled system error
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        sig_serr <= `STICKY_RESET;
    else
        sig_serr <= set_sig_serr | (sig_serr & ~clr_sig_serr);
end

// received master abort
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        rcv_mabort <= `STICKY_RESET;
    else
        rcv_mabort <= set_rcv_mabort | (rcv_mabort & ~clr_rcv_mabort);
end

// received target abort
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        rcv_tabort <= `STICKY_RESET;
    else
        rcv_tabort <= set_rcv_tabort | (rcv_tabort & ~clr_rcv_tabort);
end

// master data parity error
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        mdata_par <= `STICKY_RESET;
    else
        mdata_par <= set_mdata_par | (mdata_par & ~clr_mdata_par);
end

// serr request to the pin driver, registered one cycle after the event
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
        o_serr_drive <= 1'h0;
    else
        o_serr_drive <= serr_event;
end

// ----------------------------------------
// strap capture and control outputs
// ----------------------------------------
// strap taken each clock after release; the eeprom loader holds it steady
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
    begin
        pm_enable <= 1'b0;
        o_par_resp_en <= 1'b0;
        o_serr_en <= 1'b0;
    end
    else
    begin
        pm_enable <= i_pm_enable;
        o_par_resp_en <= next_command[`CMD_PAR_RESP] & i_cfg_wr & hit_cs |
                         command[`CMD_PAR_RESP] & ~(i_cfg_wr & hit_cs);
        o_serr_en <= next_command[`CMD_SERR_EN] & i_cfg_wr & hit_cs |
                     command[`CMD_SERR_EN] & ~(i_cfg_wr & hit_cs);
    end
end

// ----------------------------------------
// read port, one cycle answer
// ----------------------------------------
always @(posedge i_clk_sys or posedge i_reset)
begin
    if (i_reset)
    begin
        o_cfg_rdata <= 32'h0000_0000;
        o_cfg_ack <= 1'b0;
    end
    else
    begin
        o_cfg_ack <= i_cfg_rd | i_cfg_wr;
        if (i_cfg_rd && hit_cs)
            o_cfg_rdata <= {status_word, 5'h00, command};
        else if (i_cfg_rd && hit_cap)
            o_cfg_rdata <= {24'h000000, pm_enable ? CAP_PTR : 8'h00};
        else
            o_cfg_rdata <= 32'h0000_0000;
    end
end

endmodule // pci_config_status_register

// ---- dv/pci_status_chk_sva.sv ----
// checker for status dword answers and command outputs
`timescale 1ns/1ps
module pci_status_chk #(parameter [7:0] CAP_PTR = 8'hdc) (
    input wire i_clk_sys, i_reset, i_cfg_wr, i_cfg_rd, o_cfg_ack, i_addr_parity_err, i_pm_enable,
    input wire o_serr_drive, o_par_resp_en, o_serr_en,
    input wire [7:0] i_cfg_addr, input wire [3:0] i_cfg_be, input wire [31:0] i_cfg_wdata, o_cfg_rdata);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    reg r4, r34;
    // remember which dword the coming answer belongs to
    always @(posedge i_clk_sys or posedge i_reset)
        if (i_reset) {r4, r34} <= 2'h0;
        else {r4, r34} <= {i_cfg_rd && i_cfg_addr == 8'h04, i_cfg_rd && i_cfg_addr == 8'h34};
    property p_ack; i_cfg_rd || i_cfg_wr |=> o_cfg_ack && !i_reset; endproperty
    a_ack: assert property (p_ack) else $error("no answer after access");
    property p_tab; r4 |-> o_cfg_rdata[27] == 1'h0; endproperty
    a_tab: assert property (p_tab) else $error("target abort bit set");
    property p_dev; r4 |-> o_cfg_rdata[26:25] == 2'h1 && o_cfg_rdata[23]; endproperty
    a_dev: assert property (p_dev) else $error("devsel or fast b2b wrong");
    property p_rsv; r4 |-> o_cfg_rdata[22:21] == 2'h0 && o_cfg_rdata[19:16] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("zero bits set");
    // the strap goes through two registers, pm_enable then the read data, so it must be steady two edges back
    property p_cap; r4 && $stable(i_pm_enable) && $past(i_pm_enable, 2) == i_pm_enable |-> o_cfg_rdata[20] == i_pm_enable; endproperty
    a_cap: assert property (p_cap) else $error("capability bit wrong");
    property p_ptr; r34 && i_pm_enable && $past(i_pm_enable, 2) |-> o_cfg_rdata == {24'h0, CAP_PTR}; endproperty
    a_ptr: assert property (p_ptr) else $error("cap pointer wrong");
    property p_serr; i_addr_parity_err && o_par_resp_en && o_serr_en |=> o_serr_drive; endproperty
    a_serr: assert property (p_serr) else $error("serr not driven");
    property p_src; o_serr_drive |-> $past(i_addr_parity_err) && $past(o_serr_en); endproperty
    a_src: assert property (p_src) else $error("serr without cause");
    property p_cmd; $past(i_cfg_wr) && $past(i_cfg_addr) == 8'h04 && $past(i_cfg_be[0]) |-> o_par_resp_en == $past(i_cfg_wdata[6]); endproperty
    a_cmd: assert property (p_cmd) else $error("parity response not written");
    c_rd: cover property (r4 && o_cfg_rdata[31]);
    c_serr: cover property (o_serr_drive);
    c_ptr: cover property (r34 && o_cfg_rdata[7:0] == CAP_PTR);
endmodule // pci_status_chk

// ---- dv/pci_host_model.sv ----
// configuration host issuing one access per call
`timescale 1ns/1ps
module pci_host_model (
    input wire i_clk_sys, input wire o_cfg_ack, input wire [31:0] o_cfg_rdata,
    output reg i_cfg_wr, output reg i_cfg_rd, output reg [7:0] i_cfg_addr,
    output reg [3:0] i_cfg_be, output reg [31:0] i_cfg_wdata);
    initial {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_be, i_cfg_wdata} = 46'h0;
    // one request pulse, answer taken while it stands after the next edge
    task acc(input w, input [7:0] a, input [3:0] b, input [31:0] d, output [31:0] q);
        begin
            @(negedge i_clk_sys);
            {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {w, !w, a, b, d};
            @(negedge i_clk_sys);
            // ack and data stand for one cycle, so look mid-cycle, not on the edge
            q = (o_cfg_ack === 1'b1) ? o_cfg_rdata : 32'hffff_ffff;
            // released data shows the inverse so stale values cannot pass
            {i_cfg_wr, i_cfg_rd, i_cfg_wdata} = {2'h0, ~d};
        end
    endtask
endmodule // pci_host_model

// ---- dv/test_pci_config_status_register.sv ----
// testbench for the configuration status register
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_pci_config_status_register;
    reg i_clk_sys = 0, i_reset = 1, i_parity_err = 0, i_addr_parity_err = 0, i_perr_seen = 0;
    reg i_master_active = 0, i_master_abort = 0, i_target_abort = 0, i_pm_enable = 0;
    wire i_cfg_wr, i_cfg_rd, o_cfg_ack, o_serr_drive, o_par_resp_en, o_serr_en;
    wire [7:0] i_cfg_addr;
    wire [3:0] i_cfg_be;
    wire [31:0] i_cfg_wdata, o_cfg_rdata;
    reg [31:0] q, m;
    integer err_total = 0, comparisons = 0, cycles = 0, k;
    pci_config_status_register pci_config_status_register_inst (.*);
    pci_host_model pci_host_model_inst (.*);
    initial forever #25 i_clk_sys = ~i_clk_sys;
    // the whole run needs well under a thousand cycles
    always @(posedge i_clk_sys) begin cycles++; if (cycles == 3000) begin err_total++; end_sim; end end
    task end_sim;
        begin
            $display("mismatches %0d comparisons %0d", err_total, comparisons);
            if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [3:0] b, input [31:0] d); pci_host_model_inst.acc(1, a, b, d, q); endtask
    task rd(input [7:0] a); pci_host_model_inst.acc(0, a, 4'hf, 32'h0, q); endtask
    // two-cycle event; index 3 is a parity report while mastering, 4 an address parity error
    task pulse(input integer e);
        begin
            @(negedge i_clk_sys);
            {i_parity_err, i_master_abort, i_target_abort, i_perr_seen, i_addr_parity_err} = 5'h10 >> e;
            i_master_active = (e == 3);
            repeat (2) @(negedge i_clk_sys);
            {i_parity_err, i_master_abort, i_target_abort, i_perr_seen, i_addr_parity_err} = 5'h0;
            repeat (2) @(negedge i_clk_sys);
        end
    endtask
    task t_reset;
        begin
            rd(8'h04);
            `CHK("status", 32'h0280_0000, q)
        end
    endtask
    // each event sets its own flag, the address parity error also the detected flag; a zero write keeps it, a one write clears it
    task t_flags;
        begin
            @(negedge i_clk_sys);
            i_pm_enable = 1;
            wr(8'h04, 4'h3, 32'h0000_0140);
            for (k = 0; k < 5; k++)
            begin
                m = k == 4 ? 32'hc000_0000 : 32'h8000_0000 >> (k == 0 ? 0 : k == 3 ? 7 : k + 1);
                pulse(k);
                wr(8'h04, 4'h8, 32'h0);
                rd(8'h04);
                `CHK("flag set", 32'h0290_0140 | m, q)
                wr(8'h04, 4'h8, m);
                rd(8'h04);
                `CHK("flag clear", 32'h0290_0140, q)
            end
            rd(8'h34);
            `CHK("cap ptr", 32'h0000_00dc, q)
        end
    endtask
    // parity response and serr off: only the detected flag may move
    task t_ignore;
        begin
            wr(8'h04, 4'h3, 32'h0);
            pulse(3);
            pulse(4);
            wr(8'h04, 4'hc, 32'h7eff_0000);
            rd(8'h04);
            `CHK("responses off", 32'h8290_0000, q)
            rd(8'h08);
            `CHK("unmapped", 32'h0, q)
        end
    endtask
    initial
    begin
        repeat (10) @(negedge i_clk_sys);
        i_reset = 0;
        t_reset;
        t_flags;
        t_ignore;
        end_sim;
    end
endmodule // test_pci_config_status_register
bind pci_config_status_register pci_status_chk #(.CAP_PTR(CAP_PTR)) pci_status_chk_inst (.*);
